// *** pkg/stind_pkg.sv ***
// constants and types shared by the status indicator block
// assumes a 50 mhz ref_clk and synchronous inputs
// How it works
// - the registration-mode output is high while registered on lte and low otherwise.
// - while searching, the activity output blinks 200 ms high then 1800 ms low.
// - in idle, the activity output blinks 1800 ms high then 200 ms low.
// - during data transfer the activity output blinks 125 ms high and low; in a call it is high.
// - the open-drain status output is driven low once powered up normally, else released.
// - with no pending report the ring output stays high.
// - each new report makes the ring output go low for one 120 ms pulse.
// - reports from any reporting port trigger the ring pulse.
// - the download strap held high before the io supply rises selects download mode.
// - in download mode the usb firmware upgrade path is enabled.
package stind_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned SEARCH_HIGH_MS = 200;
  localparam int unsigned SEARCH_LOW_MS = 1800;
  localparam int unsigned IDLE_HIGH_MS = 1800;
  localparam int unsigned IDLE_LOW_MS = 200;
  localparam int unsigned DATA_HIGH_MS = 125;
  localparam int unsigned DATA_LOW_MS = 125;
  localparam int unsigned RING_LOW_MS = 120;
  localparam int unsigned MS_W = 11;
  localparam int unsigned PORT_COUNT = 3;

  typedef enum logic [2:0] {
    STIND_NET_OFF,
    STIND_NET_SEARCH,
    STIND_NET_IDLE,
    STIND_NET_DATA,
    STIND_NET_VOICE
  } stind_net_type;
endpackage

// *** hdl/stind_tick.sv ***
// millisecond tick generator
// assumes ref_clk runs at the package rate
`timescale 1ns/1ps
module stind_tick #(
  parameter int unsigned CYCLES = stind_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  output logic ms_tick
);
  import stind_pkg::*;
  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;

  always_comb begin
    if (cnt_ff == 17'(CYCLES - 1)) begin
      nxt_cnt = 17'h0;
    end else begin
      nxt_cnt = cnt_ff + 17'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_ff <= 17'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign ms_tick = (cnt_ff == 17'(CYCLES - 1));
endmodule

// *** hdl/stind_top.sv ***
// network indicator, status, ring and download strap logic
// assumes firmware supplies network state and report strobes synchronously
`timescale 1ns/1ps
module stind_top #(
  parameter int unsigned TICK_CYCLES_P = stind_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire stind_pkg::stind_net_type net_state,
  input wire logic lte_registered,
  input wire logic powered_up,
  input wire logic [stind_pkg::PORT_COUNT-1:0] report_strobe,
  input wire logic download_strap,
  input wire logic external_io_supply,
  output logic registration_mode_out,
  output logic network_activity_out,
  output logic ring_indicator_out,
  output logic status_od_out,
  output logic status_od_oe,
  output logic download_mode,
  output logic usb_upgrade_en
);
  import stind_pkg::*;

  // ms length of one blink phase; non-blinking states get a harmless length
  function automatic logic [MS_W-1:0] stind_phase_len(
    input stind_net_type net,
    input logic hi
  );
    logic [MS_W-1:0] len;
    case (net)
      STIND_NET_SEARCH: begin
        len = hi ? MS_W'(SEARCH_HIGH_MS) : MS_W'(SEARCH_LOW_MS);
      end
      STIND_NET_IDLE: begin
        len = hi ? MS_W'(IDLE_HIGH_MS) : MS_W'(IDLE_LOW_MS);
      end
      STIND_NET_DATA: begin
        len = hi ? MS_W'(DATA_HIGH_MS) : MS_W'(DATA_LOW_MS);
      end
      default: begin
        len = MS_W'(SEARCH_HIGH_MS);
      end
    endcase
    return len;
  endfunction

  // states whose activity output follows the blink phase
  function automatic logic stind_blinks(input stind_net_type net);
    logic res;
    case (net)
      STIND_NET_SEARCH, STIND_NET_IDLE, STIND_NET_DATA: begin
        res = 1'b1;
      end
      default: begin
        res = 1'b0;
      end
    endcase
    return res;
  endfunction

  logic ms_tick;
  stind_tick #(.CYCLES(TICK_CYCLES_P)) u_tick (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ms_tick(ms_tick)
  );

  // blink pattern
  stind_net_type state_ff;
  logic [MS_W-1:0] ms_ff;
  logic phase_hi_ff;
  logic act_ff;
  logic reg_ff;
  stind_net_type nxt_state;
  logic [MS_W-1:0] nxt_ms;
  logic nxt_phase_hi;
  logic nxt_act;
  logic nxt_reg;
  logic blinking;
  logic [MS_W-1:0] hi_len;
  logic [MS_W-1:0] lo_len;

  always_comb begin
    blinking = stind_blinks(net_state);
    hi_len = stind_phase_len(net_state, 1'b1);
    lo_len = stind_phase_len(net_state, 1'b0);
  end

  always_comb begin
    nxt_state = net_state;
    nxt_ms = ms_ff;
    nxt_phase_hi = phase_hi_ff;
    nxt_reg = lte_registered;
    if (net_state != state_ff) begin
      nxt_ms = '0;
      nxt_phase_hi = 1'b1;
    end else if (ms_tick && blinking) begin
      if (ms_ff == (phase_hi_ff ? hi_len : lo_len) - MS_W'(1)) begin
        nxt_ms = '0;
        nxt_phase_hi = !phase_hi_ff;
      end else begin
        nxt_ms = ms_ff + MS_W'(1);
      end
    end
    case (net_state)
      STIND_NET_VOICE: nxt_act = 1'b1;
      STIND_NET_SEARCH, STIND_NET_IDLE, STIND_NET_DATA: nxt_act = nxt_phase_hi;
      default: nxt_act = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= STIND_NET_OFF;
      ms_ff <= '0;
      phase_hi_ff <= 1'b1;
      act_ff <= 1'b0;
      reg_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ms_ff <= nxt_ms;
      phase_hi_ff <= nxt_phase_hi;
      act_ff <= nxt_act;
      reg_ff <= nxt_reg;
    end
  end

  assign registration_mode_out = reg_ff;
  assign network_activity_out = act_ff;

  // ring pulse; a report during a pulse restarts it
  logic ring_ff;
  logic [MS_W-1:0] ring_ms_ff;
  logic nxt_ring;
  logic [MS_W-1:0] nxt_ring_ms;
  logic any_report;

  always_comb begin
    any_report = |report_strobe;
    nxt_ring = ring_ff;
    nxt_ring_ms = ring_ms_ff;
    if (any_report) begin
      nxt_ring = 1'b1;
      nxt_ring_ms = '0;
    end else if (ring_ff && ms_tick) begin
      if (ring_ms_ff == MS_W'(RING_LOW_MS - 1)) begin
        nxt_ring = 1'b0;
        nxt_ring_ms = '0;
      end else begin
        nxt_ring_ms = ring_ms_ff + MS_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ring_ff <= 1'b0;
      ring_ms_ff <= '0;
    end else begin
      ring_ff <= nxt_ring;
      ring_ms_ff <= nxt_ring_ms;
    end
  end

  assign ring_indicator_out = !ring_ff;

  // status open drain and download strap
  logic stat_ff;
  logic supply_seen_ff;
  logic dl_ff;
  logic nxt_stat;
  logic nxt_supply_seen;
  logic nxt_dl;

  always_comb begin
    nxt_stat = powered_up;
    nxt_supply_seen = supply_seen_ff | external_io_supply;
    nxt_dl = dl_ff;
    if (external_io_supply && !supply_seen_ff) begin
      nxt_dl = download_strap;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stat_ff <= 1'b0;
      supply_seen_ff <= 1'b0;
      dl_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      supply_seen_ff <= nxt_supply_seen;
      dl_ff <= nxt_dl;
    end
  end

  assign status_od_out = 1'b0;
  assign status_od_oe = stat_ff;
  assign download_mode = dl_ff;
  assign usb_upgrade_en = dl_ff;

  // checks
  // ms ticks since the last report while the ring pulse is on
  logic [MS_W-1:0] low_run_ff;
  logic [MS_W-1:0] nxt_low_run;

  always_comb begin
    nxt_low_run = low_run_ff;
    if (!ring_ff || any_report) begin
      nxt_low_run = '0;
    end else if (ms_tick) begin
      nxt_low_run = low_run_ff + MS_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      low_run_ff <= '0;
    end else begin
      low_run_ff <= nxt_low_run;
    end
  end

  // ring, registration, blink phase, status and strap checks
  a_ring_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(ring_indicator_out) |-> low_run_ff == MS_W'(RING_LOW_MS))
    else $error("ring low pulse of wrong length");
  a_ring_retrig: assert property (@(posedge ref_clk) disable iff (!reset_n)
    any_report |=> (ring_ff && ring_ms_ff == '0 && low_run_ff == '0))
    else $error("report did not restart ring pulse");
  a_ring_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ring_ff && !ms_tick) |=> ring_ff)
    else $error("ring pulse ended between ticks");
  a_ring_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    any_report |=> !ring_indicator_out)
    else $error("report did not start ring pulse");
  a_ring_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!ring_ff && !any_report) |=> ring_indicator_out)
    else $error("ring low without report");
  a_reg_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> registration_mode_out == $past(lte_registered))
    else $error("registration output wrong");
  a_voice_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (net_state == STIND_NET_VOICE) |=> network_activity_out)
    else $error("voice call not high");
  a_phase_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (net_state != state_ff) |=> (ms_ff == '0 && phase_hi_ff))
    else $error("pattern not restarted");
  a_search_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == STIND_NET_SEARCH && phase_hi_ff) |-> ms_ff < MS_W'(SEARCH_HIGH_MS))
    else $error("search high phase too long");
  a_idle_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == STIND_NET_IDLE && !phase_hi_ff) |-> ms_ff < MS_W'(IDLE_LOW_MS))
    else $error("idle low phase too long");
  a_status_drive: assert property (@(posedge ref_clk) disable iff (!reset_n)
    powered_up |=> (status_od_oe && !status_od_out))
    else $error("status not driven low");
  a_dl_usb: assert property (@(posedge ref_clk) disable iff (!reset_n)
    download_mode |-> usb_upgrade_en)
    else $error("usb upgrade off in download mode");
  a_dl_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (external_io_supply && !supply_seen_ff) |=> download_mode == $past(download_strap))
    else $error("strap not captured");
  a_ring_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    low_run_ff <= MS_W'(RING_LOW_MS))
    else $error("ring counter overrun");

  // blink checks
  a_search_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == STIND_NET_SEARCH && !phase_hi_ff) |-> ms_ff < MS_W'(SEARCH_LOW_MS))
    else $error("search low phase too long");
  a_idle_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == STIND_NET_IDLE && phase_hi_ff) |-> ms_ff < MS_W'(IDLE_HIGH_MS))
    else $error("idle high phase too long");
  a_data_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == STIND_NET_DATA && phase_hi_ff) |-> ms_ff < MS_W'(DATA_HIGH_MS))
    else $error("data high phase too long");
  a_data_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == STIND_NET_DATA && !phase_hi_ff) |-> ms_ff < MS_W'(DATA_LOW_MS))
    else $error("data low phase too long");
  a_act_phase: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stind_blinks(net_state) |=> network_activity_out == phase_hi_ff)
    else $error("activity does not follow blink phase");
  a_phase_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == $past(state_ff) && phase_hi_ff != $past(phase_hi_ff))
    |-> $past(ms_ff) == stind_phase_len(state_ff, $past(phase_hi_ff)) - MS_W'(1))
    else $error("blink phase ended early");
  a_off_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (net_state == STIND_NET_OFF) |=> !network_activity_out)
    else $error("activity high while off");
  a_state_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> state_ff == $past(net_state))
    else $error("network state not registered");
  a_tick_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ms_tick |=> !ms_tick)
    else $error("ms ticks back to back");

  // status and strap checks
  a_status_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !powered_up |=> !status_od_oe)
    else $error("status driven while not powered up");
  a_dl_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    supply_seen_ff |=> $stable(download_mode))
    else $error("download mode changed after capture");
endmodule

// *** verif/stind_host_gpio.sv ***
// host gpio model watching the open-drain status pin
// assumes an external pull-up resistor on the pin
`timescale 1ns/1ps
module stind_host_gpio (
  input wire logic status_od_out,
  input wire logic status_od_oe,
  output logic status_pin
);
  // a released pin is pulled up, never left at the last level
  assign status_pin = status_od_oe ? status_od_out : 1'h1;
endmodule

// *** verif/stind_top_tb.sv ***
// self-checking bench for the status indicator block
// assumes a 50 mhz clock; the ms tick is shortened to TK cycles
`timescale 1ns/1ps
module stind_top_tb;
  import stind_pkg::*;
  localparam int TK = 5;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  stind_net_type net_state = STIND_NET_OFF;
  logic lte_registered = 1'h0;
  logic powered_up = 1'h0;
  logic [PORT_COUNT-1:0] report_strobe = {PORT_COUNT{1'h0}};
  logic download_strap = 1'h0;
  logic external_io_supply = 1'h0;
  logic reg_mode, act, ring, od_out, od_oe, dl, usb_en, status_pin;
  int mismatches = 0;
  int checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  stind_top #(.TICK_CYCLES_P(TK)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .net_state(net_state), .lte_registered(lte_registered), .powered_up(powered_up),
    .report_strobe(report_strobe), .download_strap(download_strap),
    .external_io_supply(external_io_supply), .registration_mode_out(reg_mode),
    .network_activity_out(act), .ring_indicator_out(ring), .status_od_out(od_out),
    .status_od_oe(od_oe), .download_mode(dl), .usb_upgrade_en(usb_en));
  stind_host_gpio host_u (.status_od_out(od_out), .status_od_oe(od_oe),
    .status_pin(status_pin));
  task automatic tick(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_cnt(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // counts cycles while the activity output stays at lvl, up to lim
  task automatic run_len(input logic lvl, input int lim, output int len);
    len = 0;
    while (act === lvl && len < lim) begin
      tick(1);
      len++;
    end
  endtask
  task automatic t_reset;
    cmp_bit("registration", 1'h0, reg_mode);
    cmp_bit("activity", 1'h0, act);
    cmp_bit("ring", 1'h1, ring);
    cmp_bit("status pin", 1'h1, status_pin);
    cmp_bit("download", 1'h0, dl);
  endtask
  task automatic t_regmode;
    lte_registered = 1'h1;
    tick(1);
    cmp_bit("registration", 1'h1, reg_mode);
    lte_registered = 1'h0;
    tick(1);
    cmp_bit("registration", 1'h0, reg_mode);
  endtask
  task automatic t_blink(input stind_net_type st, input int hi, input int lo);
    int len;
    net_state = st;
    tick(2);
    cmp_bit("activity first phase", 1'h1, act);
    run_len(1'h1, 20000, len);
    run_len(1'h0, 20000, len);
    cmp_cnt("activity low", lo * TK, lo * TK, len);
    run_len(1'h1, 20000, len);
    cmp_cnt("activity high", hi * TK, hi * TK, len);
  endtask
  task automatic t_steady(input stind_net_type st, input logic lvl);
    int len;
    net_state = st;
    tick(2);
    run_len(lvl, 3000, len);
    cmp_cnt("activity steady", 3000, 3000, len);
  endtask
  task automatic t_status;
    powered_up = 1'h1;
    tick(1);
    cmp_bit("status pin", 1'h0, status_pin);
    powered_up = 1'h0;
    tick(1);
    cmp_bit("status oe", 1'h0, od_oe);
    cmp_bit("status pin", 1'h1, status_pin);
  endtask
  task automatic t_ring(input int port);
    int len;
    report_strobe[port] = 1'h1;
    tick(1);
    report_strobe = {PORT_COUNT{1'h0}};
    cmp_bit("ring start", 1'h0, ring);
    len = 0;
    while (ring === 1'h0 && len < 2000) begin
      tick(1);
      len++;
    end
    cmp_cnt("ring low", (RING_LOW_MS - 1) * TK + 1, RING_LOW_MS * TK, len);
    tick(10);
    cmp_bit("ring idle", 1'h1, ring);
  endtask
  task automatic t_strap;
    reset_n = 1'h0;
    external_io_supply = 1'h0;
    tick(5);
    reset_n = 1'h1;
    // strap goes high after reset release and stays high until after the io supply rises
    download_strap = 1'h1;
    tick(30 * TK);
    external_io_supply = 1'h1;
    tick(2);
    download_strap = 1'h0;
    tick(2);
    cmp_bit("download mode", 1'h1, dl);
    cmp_bit("usb upgrade", 1'h1, usb_en);
    reset_n = 1'h0;
    external_io_supply = 1'h0;
    tick(5);
    reset_n = 1'h1;
    tick(1);
    external_io_supply = 1'h1;
    tick(2);
    download_strap = 1'h1;
    tick(2);
    cmp_bit("download mode", 1'h0, dl);
    cmp_bit("usb upgrade", 1'h0, usb_en);
  endtask
  task automatic conclude;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    mismatches++;
    conclude();
  end
  initial begin
    tick(5);
    reset_n = 1'h1;
    tick(1);
    t_reset();
    t_regmode();
    t_blink(STIND_NET_SEARCH, SEARCH_HIGH_MS, SEARCH_LOW_MS);
    t_blink(STIND_NET_IDLE, IDLE_HIGH_MS, IDLE_LOW_MS);
    t_blink(STIND_NET_DATA, DATA_HIGH_MS, DATA_LOW_MS);
    t_steady(STIND_NET_VOICE, 1'h1);
    t_steady(STIND_NET_OFF, 1'h0);
    t_status();
    for (int p = 0; p < PORT_COUNT; p++) begin
      t_ring(p);
    end
    t_strap();
    conclude();
  end
endmodule
